// file: include/acwd_pkg.sv
// Constants and types shared by the control-word decoder
package acwd_pkg;
    localparam int WORD_W = 16;
    localparam int SEL_BIT = 15;          // 0: mode control, 1: configuration
    localparam int PREFIX_HI = 15;
    localparam int PREFIX_LO = 11;
    localparam logic [4:0] CFG_PREFIX = 5'h10;
    // Mode-control word fields
    localparam int SCAN_HI = 14;
    localparam int SCAN_LO = 11;
    localparam int CHAN_HI = 10;
    localparam int CHAN_LO = 7;
    localparam int PM_HI = 5;
    localparam int PM_LO = 4;
    localparam int SWCONV_BIT = 1;
    localparam int CLKSEL_BIT = 3;        // Internal clock select in mode word
    // Configuration word fields
    localparam int REF_SEL_BIT = 10;
    localparam int AVG_EN_BIT = 9;
    localparam int SPD_HI = 1;
    localparam int SPD_LO = 0;
    // Scan codes
    localparam logic [3:0] SCAN_SEQ = 4'h9;
    localparam logic [3:0] SCAN_RESET = 4'h0;
    // Power modes
    localparam logic [1:0] PM_NORMAL = 2'h0;
    localparam logic [1:0] PM_SHDN = 2'h1;
    localparam logic [1:0] PM_STBY = 2'h2;
    // Reset values
    localparam logic REF_SEL_RST = 1'b0;
    localparam logic AVG_EN_RST = 1'b0;
    localparam logic [1:0] SPD_RST = 2'h0;
    localparam logic [1:0] PM_RST = 2'h0;
    localparam logic [3:0] CHAN_RST = 4'h0;
    // Discarded cycles after wake
    localparam logic [1:0] WAKE_DISCARD = 2'h2;
    localparam int SEQ_DEPTH = 256;
    localparam int BIT_CNT_W = 5;
    typedef enum logic [1:0] {ACWD_AWAKE, ACWD_ARMED, ACWD_ASLEEP} acwd_pwr_t;
endpackage

// file: hw/acwd_decoder.sv
// Serial control-word decoder with power-management sequencing
`timescale 1ns/1ps
module acwd_decoder #(
    parameter int SEQ_LEN = acwd_pkg::SEQ_DEPTH
) (
    input wire logic clk, // 25 MHz system clock
    input wire logic rstn, // Async reset, active low
    input wire logic sclk, // Serial clock pin
    input wire logic cs_n, // Chip select pin, active low
    input wire logic din, // Serial data pin
    input wire logic conversion_start_pin_n, // Start pin, active low
    input wire logic conversions_done, // All requested conversions finished
    input wire logic [7:0] seq_len_m1, // Sequence list length minus one
    input wire logic seq_step, // Advance sequence pointer
    output logic [3:0] scan_mode, // Active scan code
    output logic [3:0] channel_select, // Selected input N
    output logic internal_clock, // Internal clock mode active
    output logic reference_select, // 1: differential reference
    output logic averaging_enable, // Effective averaging
    output logic [1:0] static_power_down_bits, // Static shutdown request
    output logic full_shutdown, // All circuitry off
    output logic bias_only, // Only bias generator on
    output logic conv_valid, // Conversion cycle result is valid
    output logic [7:0] seq_index // Sequence list pointer
);
    // Pointer is 8 bits wide, so longer lists cannot be served
    if (SEQ_LEN < 1 || SEQ_LEN > acwd_pkg::SEQ_DEPTH)
    begin : g_bad_seq_len
        $error("SEQ_LEN out of range");
    end

    // ==========================================
    // Pin synchronisers and edge detection
    logic [2:0] sck_s_q, sck_s_d, cs_s_q, cs_s_d, cnv_s_q, cnv_s_d;
    logic [1:0] din_s_q, din_s_d;
    logic sck_rise, cs_fall, cs_rise, cnv_fall;

    always_comb
    begin
        sck_s_d = {sck_s_q[1:0], sclk};
        cs_s_d = {cs_s_q[1:0], cs_n};
        cnv_s_d = {cnv_s_q[1:0], conversion_start_pin_n};
        din_s_d = {din_s_q[0], din};
        sck_rise = sck_s_q[1] & ~sck_s_q[2];
        cs_fall = ~cs_s_q[1] & cs_s_q[2];
        cs_rise = cs_s_q[1] & ~cs_s_q[2];
        cnv_fall = ~cnv_s_q[1] & cnv_s_q[2];
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            sck_s_q <= 3'h0;
            cs_s_q <= 3'h7;
            cnv_s_q <= 3'h7;
            din_s_q <= 2'h0;
        end
        else
        begin
            sck_s_q <= sck_s_d;
            cs_s_q <= cs_s_d;
            cnv_s_q <= cnv_s_d;
            din_s_q <= din_s_d;
        end
    end

    // ==========================================
    // Shift register
    logic [15:0] shift_q, shift_d;
    logic [4:0] bits_q, bits_d;
    logic word_ok;

    always_comb
    begin
        shift_d = shift_q;
        bits_d = bits_q;
        if (cs_fall)
            bits_d = 5'h0;
        else if (sck_rise && !cs_s_q[1])
        begin
            shift_d = {shift_q[14:0], din_s_q[1]};
            if (bits_q != 5'h1f)
                bits_d = bits_q + 5'h1;
        end
        word_ok = cs_rise && (bits_q == 5'(acwd_pkg::WORD_W));
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            shift_q <= 16'h0;
            bits_q <= 5'h0;
        end
        else
        begin
            shift_q <= shift_d;
            bits_q <= bits_d;
        end
    end

    // ==========================================
    // Register decode
    logic [3:0] scan_q, scan_d, chan_q, chan_d;
    logic [1:0] pm_q, pm_d, spd_q, spd_d;
    logic intclk_q, intclk_d, ref_q, ref_d, avg_q, avg_d, swconv_q, swconv_d;
    logic null_code, is_cfg, is_mode;

    always_comb
    begin
        scan_d = scan_q;
        chan_d = chan_q;
        pm_d = pm_q;
        intclk_d = intclk_q;
        ref_d = ref_q;
        avg_d = avg_q;
        spd_d = spd_q;
        swconv_d = 1'b0;
        is_mode = word_ok && !shift_q[acwd_pkg::SEL_BIT];
        is_cfg = word_ok && (shift_q[acwd_pkg::PREFIX_HI:acwd_pkg::PREFIX_LO]
            == acwd_pkg::CFG_PREFIX);
        null_code = shift_q[acwd_pkg::SCAN_HI:acwd_pkg::SCAN_LO]
            > acwd_pkg::SCAN_SEQ;
        if (is_mode && !null_code)
        begin
            scan_d = shift_q[acwd_pkg::SCAN_HI:acwd_pkg::SCAN_LO];
            chan_d = shift_q[acwd_pkg::CHAN_HI:acwd_pkg::CHAN_LO];
            pm_d = shift_q[acwd_pkg::PM_HI:acwd_pkg::PM_LO];
            intclk_d = shift_q[acwd_pkg::CLKSEL_BIT];
            swconv_d = shift_q[acwd_pkg::SWCONV_BIT];
            if (scan_d == acwd_pkg::SCAN_SEQ)
                intclk_d = 1'b0;
        end
        if (is_cfg)
        begin
            ref_d = shift_q[acwd_pkg::REF_SEL_BIT];
            avg_d = shift_q[acwd_pkg::AVG_EN_BIT];
            spd_d = shift_q[acwd_pkg::SPD_HI:acwd_pkg::SPD_LO];
        end
    end

    // Power state never resets registers, so contents survive sleep
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            scan_q <= acwd_pkg::SCAN_RESET;
            chan_q <= acwd_pkg::CHAN_RST;
            pm_q <= acwd_pkg::PM_RST;
            intclk_q <= 1'b0;
            ref_q <= acwd_pkg::REF_SEL_RST;
            avg_q <= acwd_pkg::AVG_EN_RST;
            spd_q <= acwd_pkg::SPD_RST;
            swconv_q <= 1'b0;
        end
        else
        begin
            scan_q <= scan_d;
            chan_q <= chan_d;
            pm_q <= pm_d;
            intclk_q <= intclk_d;
            ref_q <= ref_d;
            avg_q <= avg_d;
            spd_q <= spd_d;
            swconv_q <= swconv_d;
        end
    end

    // ==========================================
    // Automatic power-down sequencing
    acwd_pkg::acwd_pwr_t pwr_q, pwr_d;
    logic [1:0] wake_q, wake_d;
    logic auto_on, auto_new;

    always_comb
    begin
        pwr_d = pwr_q;
        wake_d = wake_q;
        auto_on = (pm_q == acwd_pkg::PM_SHDN) || (pm_q == acwd_pkg::PM_STBY);
        // Judged on the word being decoded, so sleep comes one frame later
        auto_new = (pm_d == acwd_pkg::PM_SHDN) || (pm_d == acwd_pkg::PM_STBY);
        if (wake_q != 2'h0 && sck_rise)
            wake_d = wake_q - 2'h1;
        case (pwr_q)
            acwd_pkg::ACWD_AWAKE:
                if (auto_new && !intclk_d && word_ok)
                    pwr_d = acwd_pkg::ACWD_ARMED;
                else if (auto_on && intclk_q && conversions_done)
                    pwr_d = acwd_pkg::ACWD_ASLEEP;
            acwd_pkg::ACWD_ARMED:
                if (!auto_new || intclk_d)
                    pwr_d = acwd_pkg::ACWD_AWAKE;
                else if (cs_rise)
                    pwr_d = acwd_pkg::ACWD_ASLEEP;
            acwd_pkg::ACWD_ASLEEP:
                if (!auto_on)
                    pwr_d = acwd_pkg::ACWD_AWAKE;
                else if (!intclk_q && cs_fall)
                begin
                    pwr_d = acwd_pkg::ACWD_AWAKE;
                    wake_d = acwd_pkg::WAKE_DISCARD;
                end
                else if (intclk_q && (cnv_fall || swconv_q))
                    pwr_d = acwd_pkg::ACWD_AWAKE;
            default:
                pwr_d = acwd_pkg::ACWD_AWAKE;
        endcase
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            pwr_q <= acwd_pkg::ACWD_AWAKE;
            wake_q <= 2'h0;
        end
        else
        begin
            pwr_q <= pwr_d;
            wake_q <= wake_d;
        end
    end

    // ==========================================
    // Sequence pointer for the arbitrary list mode
    logic [7:0] idx_q, idx_d;

    always_comb
    begin
        idx_d = idx_q;
        if (word_ok || scan_q != acwd_pkg::SCAN_SEQ)
            idx_d = 8'h0;
        else if (seq_step)
            idx_d = (idx_q >= seq_len_m1 || 32'(idx_q) >= SEQ_LEN - 1)
                ? 8'h0 : idx_q + 8'h1;
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            idx_q <= 8'h0;
        else
            idx_q <= idx_d;
    end

    // ==========================================
    // Outputs
    always_comb
    begin
        scan_mode = scan_q;
        channel_select = chan_q;
        internal_clock = intclk_q;
        reference_select = ref_q;
        averaging_enable = avg_q && intclk_q
            && (scan_q != acwd_pkg::SCAN_SEQ);
        static_power_down_bits = spd_q;
        full_shutdown = (spd_q == acwd_pkg::PM_SHDN)
            || (pwr_q == acwd_pkg::ACWD_ASLEEP
                && pm_q == acwd_pkg::PM_SHDN);
        bias_only = (spd_q == acwd_pkg::PM_STBY)
            || (pwr_q == acwd_pkg::ACWD_ASLEEP
                && pm_q == acwd_pkg::PM_STBY);
        conv_valid = (pwr_q != acwd_pkg::ACWD_ASLEEP) && (wake_q == 2'h0);
        seq_index = idx_q;
    end
endmodule

// file: sim/acwd_host_model.sv
// Host model: shifts control words into the decoder
`timescale 1ns/1ps
module acwd_host_model (
    input wire logic clk, // Paces the link
    input wire logic conv_valid, // Result valid
    output logic sclk, // Serial clock, idle low
    output logic cs_n, // Select, active low
    output logic din, // Serial data
    output int n_discard // Invalid cycles last frame
);
    // ======
    // Frame driver
    initial
    begin
        sclk = 1'b0;
        cs_n = 1'b1;
        din = 1'b0;
        n_discard = 0;
    end
    // Half of a 320 ns link period
    task automatic half();
        repeat (4) @(posedge clk);
        #1;
    endtask
    task automatic send(input logic [15:0] w, input logic short);
        n_discard = 0;
        half();
        cs_n = 1'b0;
        for (int i = 15; i >= int'(short); i--)
        begin
            din = w[i];
            half();
            if (conv_valid !== 1'b1)
                n_discard++;
            sclk = 1'b1;
            half();
            sclk = 1'b0;
        end
        half();
        cs_n = 1'b1;
        // Released line shows no stale bit
        din = ~din;
        repeat (3) half();
    endtask
endmodule

// file: sim/acwd_decoder_monitor.sv
// Assertions on the decoder's ports
`timescale 1ns/1ps
module acwd_decoder_monitor (
    input wire logic clk, // Clock
    input wire logic rstn, // Reset
    input wire logic cs_n, // Select
    input wire logic seq_step, // Step
    input wire logic [7:0] seq_len_m1, // Length
    input wire logic [3:0] scan_mode, // Scan
    input wire logic [3:0] channel_select, // Channel
    input wire logic internal_clock, // Int clock
    input wire logic averaging_enable, // Averaging
    input wire logic [1:0] static_power_down_bits, // Static
    input wire logic full_shutdown, // Off
    input wire logic bias_only, // Standby
    input wire logic conv_valid, // Valid
    input wire logic [7:0] seq_index // Index
);
    // ======
    // Properties
    default clocking @(posedge clk);
    endclocking
    default disable iff (!rstn);
    property p_full;
        static_power_down_bits == 2'h1 |-> full_shutdown;
    endproperty
    a_full: assert property (p_full) else $error("full off");
    property p_bias;
        static_power_down_bits == 2'h2 |-> bias_only && !full_shutdown;
    endproperty
    a_bias: assert property (p_bias) else $error("bias");
    property p_seq;
        scan_mode == acwd_pkg::SCAN_SEQ |-> !internal_clock && !averaging_enable;
    endproperty
    a_seq: assert property (p_seq) else $error("seq clock");
    property p_avg;
        averaging_enable |-> internal_clock;
    endproperty
    a_avg: assert property (p_avg) else $error("averaging");
    property p_null;
        scan_mode <= acwd_pkg::SCAN_SEQ;
    endproperty
    a_null: assert property (p_null) else $error("null code");
    property p_frame;
        $changed(channel_select) |-> cs_n && $past(cs_n, 2);
    endproperty
    a_frame: assert property (p_frame) else $error("mid frame");
    property p_sleep;
        (full_shutdown || bias_only) && static_power_down_bits == 2'h0
            |-> !conv_valid;
    endproperty
    a_sleep: assert property (p_sleep) else $error("valid");
    property p_step;
        seq_step && scan_mode == acwd_pkg::SCAN_SEQ
            |=> seq_index == ($past(seq_index) < $past(seq_len_m1)
                ? $past(seq_index) + 8'h01 : 8'h00);
    endproperty
    a_step: assert property (p_step) else $error("index");
    c_seq: cover property (seq_step && scan_mode == acwd_pkg::SCAN_SEQ);
    c_off: cover property ($rose(full_shutdown));
    c_wake: cover property ($rose(conv_valid));
endmodule

// file: sim/acwd_decoder_test.sv
// Self-checking bench for the control-word decoder
`timescale 1ns/1ps
module acwd_decoder_test;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic start_n = 1'b1;
    logic done = 1'b0;
    logic step = 1'b0;
    logic [7:0] len = 8'h00;
    logic sclk, cs_n, din, internal_clock, reference_select;
    logic averaging_enable, full_shutdown, bias_only, conv_valid;
    logic [3:0] scan_mode, channel_select, sc, ch;
    logic [1:0] static_power_down_bits;
    logic [7:0] seq_index;
    logic ic, rf, av;
    int n_errors = 0;
    int compares = 0;
    int nd;
    always #20 clk = ~clk;
    acwd_host_model i_host (.clk, .conv_valid, .sclk, .cs_n, .din,
        .n_discard(nd));
    acwd_decoder i_dut (.clk, .rstn, .sclk, .cs_n, .din,
        .conversion_start_pin_n(start_n), .conversions_done(done),
        .seq_len_m1(len), .seq_step(step), .scan_mode, .channel_select,
        .internal_clock, .reference_select, .averaging_enable,
        .static_power_down_bits, .full_shutdown, .bias_only, .conv_valid,
        .seq_index);
    // ======
    // Helpers
    task automatic chk(input string s, input logic [7:0] e,
        input logic [7:0] g);
        compares++;
        if (g !== e)
        begin
            n_errors++;
            $display("unexpected %s: expected %h seen %h", s, e, g);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic mode(input logic [1:0] pm, input logic sw);
        i_host.send({1'b0, sc, ch, 1'b0, pm, ic, 1'b0, sw, 1'b0}, 1'b0);
    endtask
    task automatic cfg(input logic [1:0] sp);
        i_host.send({5'h10, rf, av, 7'h00, sp}, 1'b0);
    endtask
    // Start passes a synchroniser, done goes straight to the power state, so the wait is bounded, not fixed
    task automatic off(input logic f, input logic b);
        repeat (20) if (full_shutdown !== f) tick(1);
        chk("power", {6'h00, f, b}, {6'h00, full_shutdown, bias_only});
    endtask
    function automatic logic avg_exp();
        return av && ic && sc != acwd_pkg::SCAN_SEQ;
    endfunction
    task automatic print_verdict();
        $display("compares %0d errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // ======
    // Tests
    initial
    begin
        void'($urandom(57244));
        tick(8);
        rstn = 1'b1;
        chk("reset", 8'h01, {3'h0, reference_select, averaging_enable,
            static_power_down_bits, conv_valid});
        for (int i = 0; i < 12; i++)
        begin
            sc = (i == 0) ? acwd_pkg::SCAN_SEQ : 4'($urandom_range(9, 0));
            ch = (i == 1) ? 4'hf : 4'($urandom_range(15, 0));
            {ic, rf, av} = 3'($urandom);
            mode(2'h0, 1'b0);
            chk("mode", {sc, ch}, {scan_mode, channel_select});
            chk("clock", {7'h00, ic && sc != acwd_pkg::SCAN_SEQ},
                {7'h00, internal_clock});
            cfg(2'h0);
            chk("cfg", {6'h00, rf, avg_exp()},
                {6'h00, reference_select, averaging_enable});
            i_host.send({1'b0, 4'ha + 4'($urandom_range(5, 0)),
                11'($urandom)}, 1'b0);
            i_host.send({5'h11, 11'($urandom)}, 1'b0);
            i_host.send({1'b0, ~sc, ~ch, 7'h00}, 1'b1);
            chk("kept", {sc, ch}, {scan_mode, channel_select});
            chk("ref", {7'h00, rf}, {7'h00, reference_select});
        end
        $display("end decode");
        for (int p = 1; p < 4; p++)
        begin
            cfg(2'(p % 3));
            chk("static", 8'(p % 3), {6'h00, static_power_down_bits});
            off(p == 1, p == 2);
        end
        sc = 4'h4;
        ic = 1'b0;
        for (int p = 1; p < 4; p++)
        begin
            mode(2'(p), 1'b0);
            mode(2'(p), 1'b0);
            off(p == 1, p == 2);
            mode(2'h0, 1'b0);
            chk("discard", (p == 3) ? 8'h00 : 8'h02, 8'(nd));
            chk("held", {sc, ch}, {scan_mode, channel_select});
        end
        $display("end power");
        ic = 1'b1;
        sc = 4'h3;
        mode(2'h1, 1'b0);
        for (int k = 0; k < 2; k++)
        begin
            done = 1'b1;
            tick(1);
            done = 1'b0;
            off(1'b1, 1'b0);
            if (k == 0)
                start_n = 1'b0;
            else
                mode(2'h1, 1'b1);
            tick(6);
            start_n = 1'b1;
            off(1'b0, 1'b0);
        end
        $display("end internal");
        ic = 1'b0;
        sc = acwd_pkg::SCAN_SEQ;
        len = 8'($urandom_range(7, 1));
        mode(2'h0, 1'b0);
        for (int k = 0; k <= int'(len); k++)
        begin
            step = 1'b1;
            tick(1);
            chk("step", 8'((k + 1) % (int'(len) + 1)), seq_index);
            step = 1'b0;
            tick(1);
        end
        chk("seq", 8'h00, seq_index);
        $display("end sequence");
        print_verdict();
    end
    initial
    begin
        #3000000;
        n_errors++;
        print_verdict();
    end
endmodule
bind acwd_decoder acwd_decoder_monitor i_mon (.clk, .rstn, .cs_n,
    .seq_step, .seq_len_m1, .scan_mode, .channel_select, .internal_clock,
    .averaging_enable, .static_power_down_bits, .full_shutdown,
    .bias_only, .conv_valid, .seq_index);
